// *** logic/ump_pkg.sv ***
// Purpose: shared constants for the uart host and modem pin block
// Assumes: 40 MHz ref_clk, pins synchronous to it except modem status and receive clock
// Notes: register offsets are 3-bit register-select codes
// ==========================================================
// package
package ump_pkg;
  // ========================================================
  // register select codes
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IEN = 3'h1;
  localparam logic [2:0] OFS_IID = 3'h2;
  localparam logic [2:0] OFS_LCTL = 3'h3;
  localparam logic [2:0] OFS_MCTL = 3'h4;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  // ========================================================
  // interrupt enable bits
  localparam int IEN_RXD = 0;
  localparam int IEN_THR = 1;
  localparam int IEN_LSE = 2;
  localparam int IEN_MSI = 3;
  // ========================================================
  // modem control bits
  localparam int MC_DTR = 0;
  localparam int MC_OUTA = 2;
  localparam int MC_OUTB = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_ACTS = 5;
  // ========================================================
  // modem status bits
  localparam int MS_DCTS = 0;
  localparam int MS_DDSR = 1;
  localparam int MS_DDCD = 3;
  localparam int MS_CTS = 4;
  localparam int MS_DSR = 5;
  localparam int MS_DCD = 7;
  // ========================================================
  // line control and fifo control bits
  localparam int LC_DLAB = 7;
  localparam int FC_FIFO = 0;
  // ========================================================
  // interrupt identity codes
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LSE = 4'h6;
  localparam logic [3:0] IID_RXD = 4'h4;
  localparam logic [3:0] IID_RTO = 4'hC;
  localparam logic [3:0] IID_THR = 4'h2;
  localparam logic [3:0] IID_MSI = 4'h0;
  localparam logic [1:0] IID_FIFO_ON = 2'h3;
  // ========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;
  localparam logic [5:0] RST_SEL = 6'h00;
endpackage : ump_pkg

// *** logic/ump_delta_det.sv ***
// Purpose: synchronise one modem status input and flag its changes
// Assumes: clear comes from a taken modem status read
// Notes: a change in the clear cycle keeps the flag set
// ==========================================================
// module
module ump_delta_det (
  // clock and control
  input logic ref_clk,
  input logic sys_rst,
  input logic clk_en,
  // status pin and clear
  input logic pin_n,
  input logic clr,
  // results
  output logic level,
  output logic delta
);
  logic s1_r, s2_r, s3_r, dl_r;
  logic s1_nxt, s2_nxt, s3_nxt, dl_nxt;
  logic chg;

  // ========================================================
  // next state
  always_comb begin
    s1_nxt = pin_n;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    chg = s2_r ^ s3_r;
    dl_nxt = chg | (dl_r & ~clr);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      dl_r <= 1'b0;
    end else if (clk_en) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      dl_r <= dl_nxt;
    end
  end

  // level reads active high, pin is active low
  assign level = ~s3_r;
  assign delta = dl_r;

  // ========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_delta_set;
    clk_en && chg |=> delta;
  endproperty
  a_delta_set: assert property (p_delta_set)
    else $error("change did not set delta flag");

  property p_delta_clr;
    clk_en && clr && !chg |=> !delta;
  endproperty
  a_delta_clr: assert property (p_delta_clr)
    else $error("read did not clear delta flag");
endmodule : ump_delta_det

// *** logic/ump_baud_gen.sv ***
// Purpose: transmit baud clock, sixteen times the bit rate
// Assumes: divisor of zero stops the clock low
// Notes: divisor of one holds the output high
// ==========================================================
// module
module ump_baud_gen (
  // clock and control
  input logic ref_clk,
  input logic sys_rst,
  input logic clk_en,
  // divisor
  input logic [15:0] divisor,
  // clock out
  output logic baud_out
);
  logic [15:0] cnt_r, cnt_nxt;
  logic out_r, out_nxt;

  // ========================================================
  // divider
  always_comb begin
    if (divisor == 16'h0000) begin
      cnt_nxt = 16'h0000;
    end else if (cnt_r == 16'h0000 || cnt_r >= divisor) begin
      cnt_nxt = divisor - 16'h0001;
    end else begin
      cnt_nxt = cnt_r - 16'h0001;
    end
    // glitch-free registered square wave, fit to feed the rx clock
    out_nxt = (divisor != 16'h0000) && (cnt_nxt >= {1'b0, divisor[15:1]});
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= ump_pkg::RST_DIV;
      out_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign baud_out = out_r;

  // ========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  property p_baud_reload;
    divisor != 16'h0000 && cnt_r == 16'h0000 && $stable(divisor)
      |=> cnt_r == $past(divisor) - 16'h0001;
  endproperty
  a_baud_reload: assert property (p_baud_reload)
    else $error("baud divider did not reload");

  property p_baud_low_half;
    divisor > 16'h0001 && $stable(divisor)
      && cnt_r < {1'b0, divisor[15:1]} |-> !baud_out;
  endproperty
  a_baud_low_half: assert property (p_baud_low_half)
    else $error("baud clock high in its low half");
endmodule : ump_baud_gen

// *** logic/ump_uart_pins.sv ***
// Purpose: host bus pins, modem pins and interrupt of a uart
// Assumes: all inputs synchronous to ref_clk except modem status and receive clock
// Notes: serial framing and fifos sit outside; they feed status in
// ==========================================================
// module
//
// Behaviour
// - register select picks the accessed register
// - strobe low passes selects, rising edge holds
// - selected only when a, b high, c low
// - baud clock is reference divided by divisor
// - baud clock clean enough to time receiver
// - cts level bit 4, change bit 0
// - cts change interrupts unless auto cts on
// - auto cts mode gates the transmitter
// - carrier level bit 7, change bit 3
// - dsr level bit 5, change bit 1
// - carrier or dsr change interrupts when enabled
// - change flags set on toggle, cleared by read
// - driver disable low unless host is reading
// - dtr active low when control bit set
// - dtr inactive on reset, loopback, bit clear
// - interrupt high while enabled source pending
// - four interrupt source groups
// - interrupt drops once serviced or reset
// - eight-bit bidirectional three-state data bus
// - receiver timed by its own clock input
// - user outputs follow bits 2, 3, inactive in loopback
module ump_uart_pins (
  // clock, reset, enable
  input logic ref_clk,
  input logic sys_rst,
  input logic clk_en,
  // host select pins
  input logic [2:0] reg_select,
  input logic addr_strobe_n,
  input logic chip_sel_a,
  input logic chip_sel_b,
  input logic chip_sel_c_n,
  // host strobes
  input logic rd_n,
  input logic wr_n,
  // host data bus
  input logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic driver_disable_n,
  output logic int_out,
  // modem pins
  input logic cts_n,
  input logic dsr_n,
  input logic dcd_n,
  output logic dtr_n,
  output logic user_out_a_n,
  output logic user_out_b_n,
  // clocks
  output logic tx_baud_clk_out,
  input logic rx_clk_in,
  output logic rx_tick,
  // serial path side
  input logic [7:0] rx_data,
  input logic rx_avail,
  input logic rx_timeout,
  input logic rx_error,
  input logic thr_empty,
  input logic [7:0] line_status,
  output logic rx_pop,
  output logic [7:0] tx_data,
  output logic tx_load,
  output logic tx_enable,
  output logic fifo_mode
);
  // ========================================================
  // declarations
  logic [5:0] sel_live, hold_r, hold_nxt, sel_eff;
  logic selected, reading, writing;
  logic rd_prev_r, rd_prev_nxt, wr_prev_r, wr_prev_nxt;
  logic rd_take, wr_take;
  logic [2:0] ofs;
  logic [7:0] ien_r, ien_nxt, mctl_r, mctl_nxt, lctl_r, lctl_nxt;
  logic [7:0] scr_r, scr_nxt, dll_r, dll_nxt, dlm_r, dlm_nxt;
  logic [7:0] fctl_r, fctl_nxt, dout_r, dout_nxt, tx_r, tx_nxt;
  logic oe_r, oe_nxt, txl_r, txl_nxt, pop_r, pop_nxt;
  logic int_r, int_nxt;
  logic [7:0] rdata, mstat, iid;
  logic msr_clr, dlab, loop_on, auto_cts;
  logic cts_lv, dsr_lv, dcd_lv, cts_d, dsr_d, dcd_d, msi_pend;
  logic rxc1_r, rxc2_r, rxc3_r, rxt_r;
  logic rxc1_nxt, rxc2_nxt, rxc3_nxt, rxt_nxt;

  // ========================================================
  // address strobe latch and chip select decode
  assign sel_live = {chip_sel_a, chip_sel_b, chip_sel_c_n, reg_select};

  always_comb begin
    hold_nxt = addr_strobe_n ? hold_r : sel_live;
    sel_eff = addr_strobe_n ? hold_r : sel_live;
    selected = sel_eff[5] & sel_eff[4] & ~sel_eff[3];
    ofs = sel_eff[2:0];
    reading = selected & ~rd_n;
    writing = selected & ~wr_n;
    rd_prev_nxt = reading;
    wr_prev_nxt = writing;
    rd_take = reading & ~rd_prev_r;
    wr_take = writing & ~wr_prev_r;
  end

  // ========================================================
  // modem status inputs
  ump_delta_det u_cts (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_n(cts_n),
    .clr(msr_clr),
    .level(cts_lv),
    .delta(cts_d)
  );

  ump_delta_det u_dsr (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_n(dsr_n),
    .clr(msr_clr),
    .level(dsr_lv),
    .delta(dsr_d)
  );

  ump_delta_det u_dcd (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_n(dcd_n),
    .clr(msr_clr),
    .level(dcd_lv),
    .delta(dcd_d)
  );

  always_comb begin
    mstat = 8'h00;
    mstat[ump_pkg::MS_CTS] = cts_lv;
    mstat[ump_pkg::MS_DCTS] = cts_d;
    mstat[ump_pkg::MS_DCD] = dcd_lv;
    mstat[ump_pkg::MS_DDCD] = dcd_d;
    mstat[ump_pkg::MS_DSR] = dsr_lv;
    mstat[ump_pkg::MS_DDSR] = dsr_d;
    msr_clr = rd_take && ofs == ump_pkg::OFS_MSTAT;
  end

  // ========================================================
  // interrupt priority and identity
  assign dlab = lctl_r[ump_pkg::LC_DLAB];
  assign loop_on = mctl_r[ump_pkg::MC_LOOP];
  assign auto_cts = mctl_r[ump_pkg::MC_ACTS];

  always_comb begin
    msi_pend = dcd_d | dsr_d | (cts_d & ~auto_cts);
    iid = {4'h0, ump_pkg::IID_NONE};
    if (ien_r[ump_pkg::IEN_LSE] && rx_error) begin
      iid[3:0] = ump_pkg::IID_LSE;
    end else if (ien_r[ump_pkg::IEN_RXD] && rx_avail) begin
      iid[3:0] = ump_pkg::IID_RXD;
    end else if (ien_r[ump_pkg::IEN_RXD] && rx_timeout && fifo_mode) begin
      iid[3:0] = ump_pkg::IID_RTO;
    end else if (ien_r[ump_pkg::IEN_THR] && thr_empty) begin
      iid[3:0] = ump_pkg::IID_THR;
    end else if (ien_r[ump_pkg::IEN_MSI] && msi_pend) begin
      iid[3:0] = ump_pkg::IID_MSI;
    end
    if (fifo_mode) begin
      iid[7:6] = ump_pkg::IID_FIFO_ON;
    end
    // pending sources are levels, so service drops them
    int_nxt = ~iid[0];
  end

  // ========================================================
  // register read mux
  always_comb begin
    unique case (ofs)
      ump_pkg::OFS_DATA: rdata = dlab ? dll_r : rx_data;
      ump_pkg::OFS_IEN: rdata = dlab ? dlm_r : ien_r;
      ump_pkg::OFS_IID: rdata = iid;
      ump_pkg::OFS_LCTL: rdata = lctl_r;
      ump_pkg::OFS_MCTL: rdata = mctl_r;
      ump_pkg::OFS_LSTAT: rdata = line_status;
      ump_pkg::OFS_MSTAT: rdata = mstat;
      ump_pkg::OFS_SCR: rdata = scr_r;
    endcase
  end

  // ========================================================
  // register writes and bus outputs
  always_comb begin
    ien_nxt = ien_r;
    mctl_nxt = mctl_r;
    lctl_nxt = lctl_r;
    scr_nxt = scr_r;
    dll_nxt = dll_r;
    dlm_nxt = dlm_r;
    fctl_nxt = fctl_r;
    tx_nxt = tx_r;
    txl_nxt = 1'b0;
    if (wr_take) begin
      unique case (ofs)
        ump_pkg::OFS_DATA: begin
          if (dlab) begin
            dll_nxt = data_in;
          end else begin
            tx_nxt = data_in;
            txl_nxt = 1'b1;
          end
        end
        ump_pkg::OFS_IEN: begin
          if (dlab) begin
            dlm_nxt = data_in;
          end else begin
            ien_nxt = {4'h0, data_in[3:0]};
          end
        end
        ump_pkg::OFS_IID: fctl_nxt = data_in;
        ump_pkg::OFS_LCTL: lctl_nxt = data_in;
        ump_pkg::OFS_MCTL: mctl_nxt = {2'b00, data_in[5:0]};
        ump_pkg::OFS_SCR: scr_nxt = data_in;
        ump_pkg::OFS_LSTAT, ump_pkg::OFS_MSTAT: begin
        end
      endcase
    end
    // data captured once per read so a clearing read shows old flags
    dout_nxt = rd_take ? rdata : dout_r;
    oe_nxt = reading;
    pop_nxt = rd_take && ofs == ump_pkg::OFS_DATA && !dlab;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hold_r <= ump_pkg::RST_SEL;
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      ien_r <= ump_pkg::RST_BYTE;
      mctl_r <= ump_pkg::RST_BYTE;
      lctl_r <= ump_pkg::RST_BYTE;
      scr_r <= ump_pkg::RST_BYTE;
      dll_r <= ump_pkg::RST_BYTE;
      dlm_r <= ump_pkg::RST_BYTE;
      fctl_r <= ump_pkg::RST_BYTE;
      tx_r <= ump_pkg::RST_BYTE;
      txl_r <= 1'b0;
      dout_r <= ump_pkg::RST_BYTE;
      oe_r <= 1'b0;
      pop_r <= 1'b0;
      int_r <= 1'b0;
    end else if (clk_en) begin
      hold_r <= hold_nxt;
      rd_prev_r <= rd_prev_nxt;
      wr_prev_r <= wr_prev_nxt;
      ien_r <= ien_nxt;
      mctl_r <= mctl_nxt;
      lctl_r <= lctl_nxt;
      scr_r <= scr_nxt;
      dll_r <= dll_nxt;
      dlm_r <= dlm_nxt;
      fctl_r <= fctl_nxt;
      tx_r <= tx_nxt;
      txl_r <= txl_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      pop_r <= pop_nxt;
      int_r <= int_nxt;
    end
  end

  // ========================================================
  // receive clock input
  always_comb begin
    rxc1_nxt = rx_clk_in;
    rxc2_nxt = rxc1_r;
    rxc3_nxt = rxc2_r;
    rxt_nxt = rxc2_r & ~rxc3_r;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxc1_r <= 1'b0;
      rxc2_r <= 1'b0;
      rxc3_r <= 1'b0;
      rxt_r <= 1'b0;
    end else if (clk_en) begin
      rxc1_r <= rxc1_nxt;
      rxc2_r <= rxc2_nxt;
      rxc3_r <= rxc3_nxt;
      rxt_r <= rxt_nxt;
    end
  end

  // ========================================================
  // transmit baud clock
  ump_baud_gen u_baud (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .divisor({dlm_r, dll_r}),
    .baud_out(tx_baud_clk_out)
  );

  // ========================================================
  // outputs
  assign data_out = dout_r;
  assign data_oe = oe_r;
  assign driver_disable_n = reading;
  assign int_out = int_r;
  assign dtr_n = ~(mctl_r[ump_pkg::MC_DTR] & ~loop_on);
  assign user_out_a_n = ~(mctl_r[ump_pkg::MC_OUTA] & ~loop_on);
  assign user_out_b_n = ~(mctl_r[ump_pkg::MC_OUTB] & ~loop_on);
  assign tx_enable = ~auto_cts | cts_lv;
  assign fifo_mode = fctl_r[ump_pkg::FC_FIFO];
  assign rx_tick = rxt_r;
  assign rx_pop = pop_r;
  assign tx_data = tx_r;
  assign tx_load = txl_r;

  // ========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence s_strobe_held;
    addr_strobe_n [*2];
  endsequence
  property p_sel_hold;
    s_strobe_held |-> $stable(sel_eff);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("held selects changed while strobe high");

  property p_unsel_nowrite;
    !selected && !wr_n |=> $stable(mctl_r) && $stable(ien_r);
  endproperty
  a_unsel_nowrite: assert property (p_unsel_nowrite)
    else $error("unselected write changed a register");

  sequence s_mctl_write(bit v);
    wr_take && ofs == ump_pkg::OFS_MCTL && data_in[ump_pkg::MC_DTR] == v
      && !data_in[ump_pkg::MC_LOOP];
  endsequence
  property p_dtr_on;
    s_mctl_write(1'b1) |=> !dtr_n;
  endproperty
  a_dtr_on: assert property (p_dtr_on)
    else $error("dtr not active after control bit set");

  property p_dtr_loop;
    loop_on |-> dtr_n && user_out_a_n && user_out_b_n;
  endproperty
  a_dtr_loop: assert property (p_dtr_loop)
    else $error("modem output active in loopback");

  property p_driver_disable_n;
    rd_n |-> !driver_disable_n;
  endproperty
  a_driver_disable_n: assert property (p_driver_disable_n)
    else $error("driver disable released without a read");

  property p_cts_gate;
    auto_cts && !cts_lv |-> !tx_enable;
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("transmitter enabled with cts inactive");

  property p_cts_noint;
    auto_cts && cts_d && !dcd_d && !dsr_d && !rx_error && !rx_avail
      && !rx_timeout && !thr_empty |=> !int_out;
  endproperty
  a_cts_noint: assert property (p_cts_noint)
    else $error("cts change interrupted in auto cts mode");

  property p_msi_int;
    ien_r[ump_pkg::IEN_MSI] && (dcd_d || dsr_d) |=> int_out;
  endproperty
  a_msi_int: assert property (p_msi_int)
    else $error("enabled modem change raised no interrupt");

  property p_int_idle;
    ien_r == 8'h00 |=> !int_out;
  endproperty
  a_int_idle: assert property (p_int_idle)
    else $error("interrupt with all sources disabled");

  property p_read_data;
    rd_take |=> data_oe && data_out == $past(rdata);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not presented");
endmodule : ump_uart_pins

// *** test/ump_modem_model.sv ***
// Purpose: far-side modem model: status pins and receive clock
// Assumes: act holds the requested active levels {dcd, dsr, cts}
// Notes: pins move off the bench clock grid to exercise the syncs
// ==========================================================
// module
module ump_modem_model (
  // commands from the bench
  input wire logic [2:0] act,
  input wire logic rx_go,
  // modem pins
  output logic cts_n,
  output logic dsr_n,
  output logic dcd_n,
  output logic rx_clk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {dcd_n, dsr_n, cts_n} = 3'h7;
    rx_clk_in = 1'b0;
  end
  // ========================================================
  // status pins, active low, changed asynchronously
  always @(act) begin
    {dcd_n, dsr_n, cts_n} <= #7 ~act;
  end
  // ========================================================
  // burst of five receive clock periods, idle low between bursts
  always @(posedge rx_go) begin
    repeat (5) begin
      #115 rx_clk_in = 1'b1;
      #115 rx_clk_in = 1'b0;
    end
  end
endmodule : ump_modem_model

// *** test/testbench.sv ***
// Purpose: self-checking bench for the uart host and modem pins
// Assumes: 40 MHz ref_clk, host selects pass through by default
// Notes: expected values come from a small model in the bench
// ==========================================================
// module
`define CHK(nm, e, g) \
  begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, sys_rst, clk_en, addr_strobe_n, rd_n, wr_n, rx_go;
  logic chip_sel_a, chip_sel_b, chip_sel_c_n;
  logic [2:0] reg_select, act, na;
  logic [7:0] data_in, data_out, rx_data, line_status, tx_data, rd_v, v;
  logic data_oe, driver_disable_n, int_out, cts_n, dsr_n, dcd_n, dtr_n;
  logic user_out_a_n, user_out_b_n, tx_baud_clk_out, rx_clk_in, rx_tick;
  logic rx_avail, rx_timeout, rx_error, thr_empty, rx_pop, tx_load;
  logic tx_enable, fifo_mode;
  logic [3:0] srcs;
  logic [31:0] seed;
  logic [2:0] tog [4] = '{3'h4, 3'h2, 3'h1, 3'h1};
  int failures, checks_done, ticks, n, d, loads, pops;
  assign {rx_timeout, thr_empty, rx_error, rx_avail} = srcs;
  ump_uart_pins dut (.ref_clk, .sys_rst, .clk_en, .reg_select,
    .addr_strobe_n, .chip_sel_a, .chip_sel_b, .chip_sel_c_n, .rd_n,
    .wr_n, .data_in, .data_out, .data_oe, .driver_disable_n, .int_out,
    .cts_n, .dsr_n, .dcd_n, .dtr_n, .user_out_a_n, .user_out_b_n,
    .tx_baud_clk_out, .rx_clk_in, .rx_tick, .rx_data, .rx_avail,
    .rx_timeout, .rx_error, .thr_empty, .line_status, .rx_pop,
    .tx_data, .tx_load, .tx_enable, .fifo_mode);
  ump_modem_model model (.act, .rx_go, .cts_n, .dsr_n, .dcd_n,
    .rx_clk_in);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // one host access; sel is {a, b, c_n}
  task automatic acc(input logic rd, input logic [2:0] o,
      input logic [7:0] din, input logic [2:0] sel);
    @(posedge ref_clk);
    reg_select <= o;
    data_in <= din;
    {chip_sel_a, chip_sel_b, chip_sel_c_n} <= sel;
    rd_n <= ~rd;
    wr_n <= rd;
    repeat (2) @(posedge ref_clk);
    #1;
    rd_v = data_out;
    `CHK("driver_disable_n", rd && sel == 3'b110, driver_disable_n)
    if (rd && sel == 3'b110) `CHK("oe", 1'b1, data_oe)
    @(posedge ref_clk);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    {chip_sel_a, chip_sel_b, chip_sel_c_n} <= 3'b110;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("oe_off", 1'b0, data_oe)
  endtask : acc
  task automatic wr(input logic [2:0] o, input logic [7:0] dv);
    acc(1'b0, o, dv, 3'b110);
  endtask : wr
  task automatic rdc(input logic [2:0] o, input logic [7:0] e);
    acc(1'b1, o, 8'h00, 3'b110);
    `CHK("rdata", e, rd_v)
  endtask : rdc
  task automatic span(input logic lv, output int c);
    c = 0;
    while (tx_baud_clk_out === lv && c < 40) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask : span
  // ========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
  // ========================================================
  // one-cycle strobes counted where they are settled
  always @(negedge ref_clk) begin
    loads += int'(tx_load === 1'b1);
    pops += int'(rx_pop === 1'b1);
  end
  // ========================================================
  // main sequence
  initial begin
    seed = 32'h76f7_dc6a;
    failures = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    addr_strobe_n = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    {chip_sel_a, chip_sel_b, chip_sel_c_n} = 3'b110;
    reg_select = 3'h0;
    data_in = 8'h00;
    rx_data = 8'h00;
    line_status = 8'h00;
    srcs = 4'h0;
    act = 3'h0;
    rx_go = 1'b0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("int", 1'b0, int_out)
    `CHK("dtr", 1'b1, dtr_n)
    // modem control outputs, loopback forced first
    for (int k = 0; k < 6; k++) begin
      v = k == 0 ? 8'h1d : k == 1 ? 8'h0d : 8'(xs());
      wr(ump_pkg::OFS_MCTL, v);
      `CHK("dtr", !(v[0] && !v[4]), dtr_n)
      `CHK("dtr_l", !(v[0] && !v[4]), dtr_n)
      `CHK("outa", !(v[2] && !v[4]), user_out_a_n)
      `CHK("outb", !(v[3] && !v[4]), user_out_b_n)
      `CHK("txen", !v[5], tx_enable)
      rdc(ump_pkg::OFS_MCTL, v & 8'h3f);
    end
    wr(ump_pkg::OFS_MCTL, 8'h00);
    // each chip select inactive in turn
    for (int k = 0; k < 3; k++) begin
      acc(1'b0, ump_pkg::OFS_MCTL, 8'h01, 3'b110 ^ (3'b100 >> k));
      acc(1'b1, ump_pkg::OFS_MCTL, 8'h00, 3'b110 ^ (3'b100 >> k));
      `CHK("dtr", 1'b1, dtr_n)
    end
    // strobe holds selects while pins wander
    @(posedge ref_clk);
    reg_select <= ump_pkg::OFS_MCTL;
    @(posedge ref_clk);
    addr_strobe_n <= 1'b1;
    @(posedge ref_clk);
    reg_select <= ump_pkg::OFS_SCR;
    {chip_sel_a, chip_sel_b, chip_sel_c_n} <= 3'b001;
    data_in <= 8'h01;
    wr_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    wr_n <= 1'b1;
    addr_strobe_n <= 1'b0;
    {chip_sel_a, chip_sel_b, chip_sel_c_n} <= 3'b110;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("dtr", 1'b0, dtr_n)
    wr(ump_pkg::OFS_MCTL, 8'h00);
    // data paths
    for (int k = 0; k < 4; k++) begin
      v = 8'(xs());
      @(posedge ref_clk);
      rx_data <= ~v;
      line_status <= v ^ 8'h5a;
      wr(ump_pkg::OFS_SCR, v);
      rdc(ump_pkg::OFS_SCR, v);
      rdc(ump_pkg::OFS_DATA, ~v);
      rdc(ump_pkg::OFS_LSTAT, v ^ 8'h5a);
      wr(ump_pkg::OFS_DATA, v);
      `CHK("txd", v, tx_data)
    end
    // modem status levels and change flags
    rdc(ump_pkg::OFS_MSTAT, 8'h00);
    for (int k = 0; k < 5; k++) begin
      na = k == 0 ? 3'h7 : 3'(xs());
      tog[0] = na ^ act;
      @(posedge ref_clk);
      act <= na;
      repeat (8) @(posedge ref_clk);
      rdc(ump_pkg::OFS_MSTAT, {na[2], 1'b0, na[1:0], tog[0][2], 1'b0,
        tog[0][1:0]});
      rdc(ump_pkg::OFS_MSTAT, {na[2], 1'b0, na[1:0], 4'h0});
    end
    tog[0] = 3'h4;
    // receive clock pulses
    ticks = 0;
    @(posedge ref_clk);
    rx_go <= 1'b1;
    repeat (100) begin
      @(posedge ref_clk);
      #1;
      ticks += int'(rx_tick === 1'b1);
    end
    rx_go <= 1'b0;
    `CHK("ticks", 5, ticks)
    // modem interrupts: dcd, dsr, cts, cts under auto mode
    wr(ump_pkg::OFS_IEN, 8'h08);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) wr(ump_pkg::OFS_MCTL, 8'h20);
      @(posedge ref_clk);
      act <= act ^ tog[k];
      repeat (8) @(posedge ref_clk);
      #1;
      `CHK("int", k != 3, int_out)
      `CHK("txen", k != 3 || act[0], tx_enable)
      rdc(ump_pkg::OFS_MSTAT, {act[2], 1'b0, act[1:0], tog[k][2], 1'b0,
        tog[k][1:0]});
      `CHK("int", 1'b0, int_out)
    end
    wr(ump_pkg::OFS_MCTL, 8'h00);
    // serial-side sources, then all masked
    wr(ump_pkg::OFS_IID, 8'h01);
    `CHK("fifo", 1'b1, fifo_mode)
    wr(ump_pkg::OFS_IEN, 8'h07);
    for (int k = 0; k < 5; k++) begin
      if (k == 4) wr(ump_pkg::OFS_IEN, 8'h00);
      @(posedge ref_clk);
      srcs <= k < 4 ? 4'(1 << k) : 4'hf;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("int", k < 4, int_out)
      @(posedge ref_clk);
      srcs <= 4'h0;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("int", 1'b0, int_out)
    end
    // transmit baud clock period from the divisor
    for (int k = 0; k < 3; k++) begin
      d = 2 + int'(xs() % 8);
      wr(ump_pkg::OFS_LCTL, 8'h80);
      wr(ump_pkg::OFS_DATA, 8'(d));
      wr(ump_pkg::OFS_IEN, 8'h00);
      wr(ump_pkg::OFS_LCTL, 8'h00);
      span(1'b1, n);
      span(1'b0, n);
      span(1'b1, n);
      `CHK("baud_hi", d - d / 2, n)
      span(1'b0, n);
      `CHK("baud_lo", d / 2, n)
    end
    // clock enable low freezes the divider mid-period
    @(posedge ref_clk);
    clk_en <= 1'b0;
    @(posedge ref_clk);
    #1;
    span(tx_baud_clk_out, n);
    `CHK("freeze", 40, n)
    @(posedge ref_clk);
    clk_en <= 1'b1;
    `CHK("loads", 4, loads)
    `CHK("pops", 4, pops)
    tally_and_finish();
  end
endmodule : testbench
